// ==== verilog/cdd_pkg.sv ====
package cdd_pkg;

  // Clock and execution timing
  localparam int unsigned CLK_FREQ_KHZ     = 250_000;
  localparam int unsigned CLEAR_TIME_NS    = 6_200_000;
  localparam int unsigned CLEAR_CYCLES_DEF = CLEAR_TIME_NS / 1000 * (CLK_FREQ_KHZ / 1000);
  localparam int unsigned EXEC_CYCLES_DEF  = 1;

  // Wishbone byte offsets of the two host registers
  localparam int unsigned ADR_W        = 4;
  localparam logic [3:0]  OFS_COMMAND  = 4'h0;
  localparam logic [3:0]  OFS_PAYLOAD  = 4'h4;

  // Bus fields
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned AC_W         = 7;
  localparam int unsigned GAC_W        = 6;
  localparam int unsigned PAN_W        = 7;

  // Text and glyph memory
  localparam int unsigned TEXT_DEPTH   = 128;
  localparam int unsigned GLYPH_DEPTH  = 64;
  localparam logic [7:0]  SPACE_CODE   = 8'h20;
  localparam logic [6:0]  AC_HOME      = 7'h00;
  localparam logic [6:0]  ONE_LINE_END = 7'h4F;
  localparam logic [6:0]  LINE1_END    = 7'h27;
  localparam logic [6:0]  LINE2_START  = 7'h40;
  localparam logic [6:0]  LINE2_END    = 7'h67;
  localparam logic [6:0]  CLEAR_LAST   = 7'h7F;

  // Command opcodes
  localparam logic [7:0]  CMD_CLEAR    = 8'h01;
  localparam logic [1:0]  SUB_SHIFT    = 2'h0;
  localparam logic [1:0]  SUB_POWER    = 2'h3;

  typedef struct packed {
    logic       screenOn;
    logic       cursorOn;
    logic       cursorBlink;
    logic       stepUp;
    logic       autoPan;
    logic       graphicMode;
    logic       dcdcOn;
    logic       busWidth8;
    logic       twoLine;
    logic       tallGlyph;
    logic       fontTableHi;
    logic       fontTableLo;
  } cdd_cfg_s;

  localparam cdd_cfg_s CFG_RESET = '{
    screenOn:    1'b0,
    cursorOn:    1'b0,
    cursorBlink: 1'b0,
    stepUp:      1'b1,
    autoPan:     1'b0,
    graphicMode: 1'b0,
    dcdcOn:      1'b0,
    busWidth8:   1'b1,
    twoLine:     1'b0,
    tallGlyph:   1'b0,
    fontTableHi: 1'b0,
    fontTableLo: 1'b0
  };

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_CLEAR = 3'b100
  } cdd_state_e;

endpackage : cdd_pkg

// ==== verilog/cdd_char_display_command_decoder.sv ====
`timescale 1ns/1ps

module cdd_char_display_command_decoder #(
  parameter int unsigned CLEAR_CYCLES = cdd_pkg::CLEAR_CYCLES_DEF,
  parameter int unsigned EXEC_CYCLES  = cdd_pkg::EXEC_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [cdd_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [cdd_pkg::DATA_W-1:0]  wb_dat_i,
  output logic                             wb_ack_o,
  output logic      [cdd_pkg::DATA_W-1:0]  wb_dat_o,
  // Display state
  output cdd_pkg::cdd_cfg_s                dispCfg,
  output logic      [cdd_pkg::AC_W-1:0]    addrCounter,
  output logic                             glyphSelect,
  output logic      [cdd_pkg::PAN_W-1:0]   panOffset,
  output logic                             busyFlag
);
  import cdd_pkg::*;

  localparam int unsigned CNT_W = $clog2(CLEAR_CYCLES + 1);

  // Address step with line-aware wrap for text memory
  function automatic logic [AC_W-1:0] stepAddr(input logic [AC_W-1:0] a, input logic up,
                                               input logic glyph, input logic twoLines);
    logic [AC_W-1:0] r;
    r = a;
    if (glyph)
    begin
      r = up ? {1'b0, a[GAC_W-1:0] + 6'h01} : {1'b0, a[GAC_W-1:0] - 6'h01};
    end
    else if (!twoLines)
    begin
      if (up)
        r = (a >= ONE_LINE_END) ? AC_HOME : a + 7'h01;
      else
        r = (a == AC_HOME || a > ONE_LINE_END) ? ONE_LINE_END : a - 7'h01;
    end
    else
    begin
      if (up)
      begin
        if (a == LINE1_END)
          r = LINE2_START;
        else if (a >= LINE2_END)
          r = AC_HOME;
        else
          r = a + 7'h01;
      end
      else
      begin
        if (a == AC_HOME)
          r = LINE2_END;
        else if (a == LINE2_START)
          r = LINE1_END;
        else
          r = a - 7'h01;
      end
    end
    return r;
  endfunction : stepAddr

  cdd_state_e       state;
  logic [CNT_W-1:0] busyCnt;
  logic             stepPending;
  logic             panPending;
  logic             nibblePhase;
  logic [NIB_W-1:0] nibbleHold;
  logic [AC_W-1:0]  clearIdx;
  logic             clearing;
  logic             wbAck;
  logic [DATA_W-1:0] wbDat;

  logic [BYTE_W-1:0] textRam  [TEXT_DEPTH];
  logic [BYTE_W-1:0] glyphRam [GLYPH_DEPTH];

  // Bus decode
  wire accept         = wb_cyc_i & wb_stb_i & ~wbAck;
  wire registerSelect = (wb_adr_i == OFS_PAYLOAD);
  wire mapped         = (wb_adr_i == OFS_COMMAND) | registerSelect;
  wire readNotWrite   = ~wb_we_i;
  wire laneWrite      = wb_we_i & wb_sel_i[0];
  wire busy           = (state != ST_IDLE);

  // Byte assembly for narrow and wide bus
  wire byteDone = dispCfg.busWidth8 | nibblePhase;
  wire [BYTE_W-1:0] commandLatch = dispCfg.busWidth8 ? wb_dat_i[BYTE_W-1:0]
                                                     : {nibbleHold, wb_dat_i[BYTE_W-1:NIB_W]};
  wire [BYTE_W-1:0] payloadLatch = commandLatch;

  // A write while busy is dropped whole, including its nibble
  wire wrOk      = accept & mapped & laneWrite & ~busy;
  wire cmdExec   = wrOk & ~registerSelect & byteDone;
  wire dataWrite = wrOk & registerSelect & byteDone;
  wire dataRead  = accept & mapped & readNotWrite & registerSelect & byteDone & ~busy;
  wire nibbleAdv = accept & mapped & ~dispCfg.busWidth8 & (readNotWrite | (laneWrite & ~busy));

  // Command decode by highest set bit
  wire [BYTE_W-1:0] c = commandLatch;
  wire isTextAddr  = cmdExec & c[7];
  wire isGlyphAddr = cmdExec & (c[7:6] == 2'h1);
  wire isFunc      = cmdExec & (c[7:5] == 3'h1);
  wire isShiftGrp  = cmdExec & (c[7:4] == 4'h1);
  wire isShift     = isShiftGrp & (c[1:0] == SUB_SHIFT);
  wire isPower     = isShiftGrp & (c[1:0] == SUB_POWER);
  wire isDisplay   = cmdExec & (c[7:3] == 5'h01);
  wire isEntry     = cmdExec & (c[7:2] == 6'h01);
  wire isHome      = cmdExec & (c[7:1] == 7'h01);
  wire isClear     = cmdExec & (c == CMD_CLEAR);

  // Busy sequencing
  wire startExec = cmdExec | dataWrite | dataRead;
  wire execEnd   = busy & (busyCnt == CNT_W'(1));
  wire stepDue   = execEnd & stepPending;

  wire [CNT_W-1:0] next_busyCnt = isClear ? CNT_W'(CLEAR_CYCLES) :
                                  startExec ? CNT_W'(EXEC_CYCLES) :
                                  execEnd ? '0 :
                                  busy ? busyCnt - CNT_W'(1) : busyCnt;

  cdd_state_e next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (isClear)
          next_state = ST_CLEAR;
        else if (startExec)
          next_state = ST_BUSY;
      end
      ST_BUSY, ST_CLEAR:
      begin
        if (execEnd)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= ST_IDLE;
      busyCnt  <= '0;
      busyFlag <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      busyCnt  <= next_busyCnt;
      busyFlag <= (next_state != ST_IDLE);
    end
  end

  // Deferred step and auto-pan of a data access
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stepPending <= 1'b0;
      panPending  <= 1'b0;
    end
    else if (dataWrite | dataRead)
    begin
      stepPending <= 1'b1;
      panPending  <= dataWrite & ~glyphSelect & dispCfg.autoPan;
    end
    else if (execEnd)
    begin
      stepPending <= 1'b0;
      panPending  <= 1'b0;
    end
  end

  // Nibble pairing on the narrow bus
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nibblePhase <= 1'b0;
      nibbleHold  <= '0;
    end
    else if (nibbleAdv)
    begin
      nibblePhase <= ~nibblePhase;
      nibbleHold  <= wb_dat_i[BYTE_W-1:NIB_W];
    end
  end

  // Settings
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      dispCfg <= CFG_RESET;
    else
    begin
      if (isClear)
        dispCfg.stepUp <= 1'b1;
      if (isEntry)
      begin
        dispCfg.stepUp  <= c[1];
        dispCfg.autoPan <= c[0];
      end
      if (isDisplay)
      begin
        dispCfg.screenOn    <= c[2];
        dispCfg.cursorOn    <= c[1];
        dispCfg.cursorBlink <= c[0];
      end
      if (isPower)
      begin
        dispCfg.graphicMode <= c[3];
        dispCfg.dcdcOn      <= c[2];
      end
      if (isFunc)
      begin
        dispCfg.busWidth8   <= c[4];
        dispCfg.twoLine     <= c[3];
        dispCfg.tallGlyph   <= c[2];
        // Code 11 is held as written; it selects no table downstream
        dispCfg.fontTableHi <= c[1];
        dispCfg.fontTableLo <= c[0];
      end
    end
  end

  // Address counter and memory target
  wire [AC_W-1:0] cursorStep = stepAddr(addrCounter, c[2], glyphSelect, dispCfg.twoLine);
  wire [AC_W-1:0] dataStep   = stepAddr(addrCounter, dispCfg.stepUp, glyphSelect, dispCfg.twoLine);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addrCounter <= AC_HOME;
      glyphSelect <= 1'b0;
    end
    else if (isClear | isHome)
    begin
      addrCounter <= AC_HOME;
      glyphSelect <= 1'b0;
    end
    else if (isTextAddr)
    begin
      addrCounter <= c[AC_W-1:0];
      glyphSelect <= 1'b0;
    end
    else if (isGlyphAddr)
    begin
      addrCounter <= {1'b0, c[GAC_W-1:0]};
      glyphSelect <= 1'b1;
    end
    else if (isShift & ~c[3])
      addrCounter <= cursorStep;
    else if (stepDue)
      addrCounter <= dataStep;
  end

  // Display pan; both lines share one offset so they move together
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      panOffset <= '0;
    else if (isClear | isHome)
      panOffset <= '0;
    else if (isShift & c[3])
      panOffset <= c[2] ? panOffset + 7'h01 : panOffset - 7'h01;
    else if (stepDue & panPending)
      panOffset <= dispCfg.stepUp ? panOffset - 7'h01 : panOffset + 7'h01;
  end

  // Clear sweep, one location per clock inside the busy window
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clearing <= 1'b0;
      clearIdx <= '0;
    end
    else if (isClear)
    begin
      clearing <= 1'b1;
      clearIdx <= '0;
    end
    else if (clearing)
    begin
      clearing <= (clearIdx != CLEAR_LAST);
      clearIdx <= clearIdx + 7'h01;
    end
  end

  // Memories carry no reset
  always_ff @(posedge sys_clk)
  begin
    if (clearing)
      textRam[clearIdx] <= SPACE_CODE;
    else if (dataWrite & ~glyphSelect)
      textRam[addrCounter] <= payloadLatch;
    if (dataWrite & glyphSelect)
      glyphRam[addrCounter[GAC_W-1:0]] <= payloadLatch;
  end

  // Read path
  wire [BYTE_W-1:0] statusByte = {busyFlag, addrCounter};
  wire [BYTE_W-1:0] ramByte    = glyphSelect ? glyphRam[addrCounter[GAC_W-1:0]] : textRam[addrCounter];
  wire [BYTE_W-1:0] readByte   = registerSelect ? ramByte : statusByte;
  wire [BYTE_W-1:0] readLane   = dispCfg.busWidth8 ? readByte :
                                 nibblePhase ? {readByte[NIB_W-1:0], 4'h0} :
                                 {readByte[BYTE_W-1:NIB_W], 4'h0};

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wbAck <= 1'b0;
      wbDat <= '0;
    end
    else
    begin
      wbAck <= accept;
      wbDat <= (accept & mapped & readNotWrite) ? {24'h00_0000, readLane} : '0;
    end
  end

  assign wb_ack_o = wbAck;
  assign wb_dat_o = wbDat;

endmodule : cdd_char_display_command_decoder

// ==== dv/cdd_checker_assertions.sv ====
`timescale 1ns/1ps
module cdd_checker #(
  parameter int unsigned CLEAR_CYCLES = cdd_pkg::CLEAR_CYCLES_DEF,
  parameter int unsigned EXEC_CYCLES  = cdd_pkg::EXEC_CYCLES_DEF
) (
  // Clock and reset
  input logic                       sys_clk,
  input logic                       nrst,
  // Bus
  input logic                       wb_cyc_i,
  input logic                       wb_stb_i,
  input logic                       wb_we_i,
  input logic [cdd_pkg::ADR_W-1:0]  wb_adr_i,
  input logic [3:0]                 wb_sel_i,
  input logic [cdd_pkg::DATA_W-1:0] wb_dat_i,
  input logic                       wb_ack_o,
  input logic [cdd_pkg::DATA_W-1:0] wb_dat_o,
  // Display state
  input cdd_pkg::cdd_cfg_s          dispCfg,
  input logic [cdd_pkg::AC_W-1:0]   addrCounter,
  input logic                       glyphSelect,
  input logic [cdd_pkg::PAN_W-1:0]  panOffset,
  input logic                       busyFlag
);
  import cdd_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0]  cmdByte;
  logic        taken;
  logic        cmdOk;
  logic [20:0] busyLen;
  assign cmdByte = wb_dat_i[7:0];
  assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Only wide-bus commands: a narrow byte acts on its second nibble
  assign cmdOk = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_COMMAND) & ~busyFlag & dispCfg.busWidth8;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      busyLen <= '0;
    else if (busyFlag)
      busyLen <= busyLen + 21'h1;
    else
      busyLen <= '0;

  property p_ack_one;
    taken |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one pulse");
  property p_busy_start;
    cmdOk |=> busyFlag;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");
  property p_refuse;
    taken && wb_we_i && busyFlag |=> $stable(dispCfg) && $stable(glyphSelect);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken while busy");
  property p_status;
    taken && !wb_we_i && wb_adr_i == OFS_COMMAND && dispCfg.busWidth8
      |=> wb_dat_o[7:0] == {$past(busyFlag), $past(addrCounter)};
  endproperty
  a_status: assert property (p_status) else $error("bad status byte");
  property p_clear;
    cmdOk && cmdByte == CMD_CLEAR |=> busyFlag && addrCounter == AC_HOME && panOffset == 7'h00
      && dispCfg.stepUp && dispCfg.autoPan == $past(dispCfg.autoPan);
  endproperty
  a_clear: assert property (p_clear) else $error("clear state wrong");
  property p_busy_len;
    $fell(busyFlag) |-> busyLen == EXEC_CYCLES || busyLen == CLEAR_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_home;
    cmdOk && cmdByte[7:1] == 7'h01 |=> addrCounter == AC_HOME && panOffset == 7'h00;
  endproperty
  a_home: assert property (p_home) else $error("home failed");
  property p_entry;
    cmdOk && cmdByte[7:2] == 6'h01 |=> dispCfg.stepUp == $past(cmdByte[1]) && dispCfg.autoPan == $past(cmdByte[0]);
  endproperty
  a_entry: assert property (p_entry) else $error("entry mode wrong");
endmodule : cdd_checker

bind cdd_char_display_command_decoder cdd_checker #(
  .CLEAR_CYCLES(CLEAR_CYCLES),
  .EXEC_CYCLES (EXEC_CYCLES)
) chk (
  .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dispCfg(dispCfg), .addrCounter(addrCounter),
  .glyphSelect(glyphSelect), .panOffset(panOffset), .busyFlag(busyFlag)
);

// ==== dv/cdd_host_model.sv ====
`timescale 1ns/1ps
module cdd_host_model (
  // Clock
  input  logic                       sys_clk,
  // Bus
  output logic                       wb_cyc_i,
  output logic                       wb_stb_i,
  output logic                       wb_we_i,
  output logic [cdd_pkg::ADR_W-1:0]  wb_adr_i,
  output logic [3:0]                 wb_sel_i,
  output logic [cdd_pkg::DATA_W-1:0] wb_dat_i,
  input  logic                       wb_ack_o,
  input  logic [cdd_pkg::DATA_W-1:0] wb_dat_o
);
  import cdd_pkg::*;
  logic       narrow;
  // Lane enables of the next access; lane 0 off makes a write that must be ignored
  logic [3:0] sel;
  initial
  begin
    narrow = 1'b0;
    sel = 4'h1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
  end
  task automatic access(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    // Byte copied to every lane; only lane 0 may reach the decoder
    wb_dat_i <= {4{d}};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Released data must not look like the last byte
    wb_dat_i <= ~{4{d}};
  endtask : access
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] hi;
    if (narrow)
    begin
      access(we, adr, {d[7:4], 4'h0}, hi);
      access(we, adr, {d[3:0], 4'h0}, q);
      q = {hi[7:4], q[7:4]};
    end
    else
      access(we, adr, d, q);
  endtask : xfer
  task automatic poll;
    logic [7:0] q;
    do xfer(1'b0, OFS_COMMAND, 8'h00, q); while (q[7] !== 1'b0);
  endtask : poll
  task automatic cmd(input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, OFS_COMMAND, d, q);
    poll();
  endtask : cmd
  task automatic data(input logic we, input logic [7:0] d, output logic [7:0] q);
    xfer(we, OFS_PAYLOAD, d, q);
    poll();
  endtask : data
endmodule : cdd_host_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import cdd_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc, wbStb, wbWe, wbAck, glyphSelect, busyFlag;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDatI, wbDatO;
  cdd_cfg_s dispCfg;
  logic [6:0] addrCounter, panOffset;
  logic [7:0] rd;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ctl [2] = '{8'h0D, 8'h0A};
  logic [7:0] pwr [2] = '{8'h1B, 8'h17};

  cdd_char_display_command_decoder #(.CLEAR_CYCLES(200), .EXEC_CYCLES(1)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_ack_o(wbAck), .wb_dat_o(wbDatO),
    .dispCfg(dispCfg), .addrCounter(addrCounter), .glyphSelect(glyphSelect),
    .panOffset(panOffset), .busyFlag(busyFlag));
  cdd_host_model host (
    .sys_clk(sys_clk), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_ack_o(wbAck), .wb_dat_o(wbDatO));

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Run is about 500 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    check(16'(dispCfg), 16'(CFG_RESET), "reset cfg");
    host.access(1'b1, 4'hB, CMD_CLEAR, rd);
    host.access(1'b0, 4'h7, 8'h00, rd);
    check(rd, 8'h00, "unmapped read");
    host.xfer(1'b0, OFS_COMMAND, 8'h00, rd);
    check(rd, 8'h00, "status idle");
    $display("test reset done");
    for (int f = 0; f < 4; f++)
    begin
      host.cmd(8'h3C | 8'(f));
      check({dispCfg.busWidth8, dispCfg.twoLine, dispCfg.tallGlyph, dispCfg.fontTableHi, dispCfg.fontTableLo},
            {3'b111, 2'(f)}, "function set");
    end
    host.cmd(8'h38);
    foreach (ctl[i])
    begin
      host.cmd(ctl[i]);
      check({dispCfg.screenOn, dispCfg.cursorOn, dispCfg.cursorBlink}, ctl[i][2:0], "display ctl");
      host.cmd(pwr[i]);
      check({dispCfg.graphicMode, dispCfg.dcdcOn}, pwr[i][3:2], "mode power");
    end
    host.sel = 4'hE;
    host.xfer(1'b1, OFS_COMMAND, 8'h0F, rd);
    host.sel = 4'h1;
    host.poll();
    check({dispCfg.screenOn, dispCfg.cursorOn, dispCfg.cursorBlink}, 3'b010, "lane off write");
    $display("test settings done");
    host.cmd(8'hA7);
    check(addrCounter, 7'h27, "text addr");
    host.data(1'b1, 8'h41, rd);
    check(addrCounter, LINE2_START, "line wrap");
    host.cmd(8'hA7);
    host.data(1'b0, 8'h00, rd);
    check(rd, 8'h41, "text read");
    host.cmd(8'h04);
    host.cmd(8'h85);
    host.data(1'b1, 8'h42, rd);
    check(addrCounter, 7'h04, "decrement");
    host.cmd(8'h07);
    host.data(1'b1, 8'h43, rd);
    check({panOffset, addrCounter}, {7'h7F, 7'h05}, "auto pan");
    host.cmd(8'h1C);
    host.cmd(8'h1C);
    check(panOffset, 7'h01, "pan right");
    host.cmd(8'h02);
    check({panOffset, addrCounter}, 14'h0000, "home");
    host.cmd(8'h14);
    check(addrCounter, 7'h01, "cursor right");
    host.cmd(8'h10);
    check(addrCounter, 7'h00, "cursor left");
    $display("test text done");
    host.cmd(8'h7F);
    host.data(1'b1, 8'h55, rd);
    check({glyphSelect, addrCounter}, 8'h80, "glyph wrap");
    host.cmd(8'h7F);
    host.data(1'b0, 8'h00, rd);
    check(rd, 8'h55, "glyph read");
    $display("test glyph done");
    host.cmd(8'h05);
    host.xfer(1'b1, OFS_COMMAND, CMD_CLEAR, rd);
    host.xfer(1'b1, OFS_COMMAND, 8'h0F, rd);
    host.xfer(1'b0, OFS_COMMAND, 8'h00, rd);
    check(rd[7], 1'b1, "busy during clear");
    check(busyFlag, 1'b1, "busy pin");
    host.poll();
    check({dispCfg.screenOn, dispCfg.cursorOn, dispCfg.cursorBlink}, 3'b010, "refused cmd");
    check({dispCfg.stepUp, dispCfg.autoPan, addrCounter}, 9'h180, "clear state");
    host.cmd(8'h90);
    host.data(1'b0, 8'h00, rd);
    check(rd, SPACE_CODE, "cleared text");
    $display("test clear done");
    // Width changes at this write, so the poll after it already pairs nibbles
    host.xfer(1'b1, OFS_COMMAND, 8'h28, rd);
    host.narrow = 1'b1;
    host.poll();
    check(dispCfg.busWidth8, 1'b0, "narrow set");
    host.cmd(8'h92);
    check(addrCounter, 7'h12, "nibble cmd");
    host.data(1'b1, 8'hA5, rd);
    host.cmd(8'h92);
    host.data(1'b0, 8'h00, rd);
    check(rd, 8'hA5, "nibble data");
    host.xfer(1'b1, OFS_COMMAND, 8'h38, rd);
    host.narrow = 1'b0;
    host.poll();
    check(dispCfg.busWidth8, 1'b1, "wide again");
    $display("test nibble done");
    print_verdict();
  end
endmodule : testbench
